// >>> pkg/alarm_pkg.sv
// constants and types for the airflow alarm annunciator
package alarm_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned TICK_SEC        = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_SEC;
    localparam int unsigned QUALIFY_SEC     = 10;
    localparam int unsigned SIREN_SEC       = 30;
    localparam int unsigned CHIRP_PERIOD_SEC = 10;
    localparam int unsigned BLINK_HALF_SEC  = 1;

    // ------------------------------------------------------------
    // pressure words and reset values
    // ------------------------------------------------------------
    localparam int unsigned PRESS_W         = 12;
    localparam logic [11:0] NOMINAL_RST     = 12'h800;
    localparam logic [11:0] LOW_OFS_RST     = 12'h100;
    localparam logic [11:0] HIGH_OFS_RST    = 12'h100;

    // ------------------------------------------------------------
    // fault indices
    // ------------------------------------------------------------
    localparam int unsigned FAULT_N         = 3;
    localparam int unsigned F_LOW           = 0;
    localparam int unsigned F_HIGH          = 1;
    localparam int unsigned F_SPEED         = 2;

    typedef enum logic [1:0] {
        SND_IDLE  = 2'b00,
        SND_SIREN = 2'b01,
        SND_CHIRP = 2'b10
    } sounder_e;

    typedef struct packed {
        logic       alarm_red;
        logic       flow_left_red;
        logic       flow_right_red;
        logic       blower_red;
        logic       blower_green;
        logic       light_blue;
        logic       bar_blink;
    } leds_s;

endpackage

// >>> src/airflow_alarm_annunciator.sv
// alarm qualification, latching, sounder and panel indicators
// ------------------------------------------------------------
// Functional notes
// - fault must persist ten seconds before annunciation
// - annunciated fault stays latched until cleared
// - sounder thirty seconds, then chirp every ten
// - blower off-on or power cycle clears faults
// - power interruption blinks alarm, any key clears
// - low pressure lights left red and alarm
// - high pressure lights right red and alarm
// - speed feedback loss blinks blower red, lights alarm steady
// - new firmware blinks whole airflow bar
// - blower commanded on lights green indicator
// - lamp commanded on lights blue indicator
// - reset loads default setup and calibration
// - limits are offsets from captured nominal pressure
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module airflow_alarm_annunciator #(
    parameter int unsigned TICK_CYCLES_P = alarm_pkg::TICK_CYCLES
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic [11:0]           pressure,
    input  wire logic                  cal_capture,
    input  wire logic [11:0]           low_offset,
    input  wire logic [11:0]           high_offset,
    input  wire logic                  offset_load,
    input  wire logic                  speed_lost,
    input  wire logic                  blower_on,
    input  wire logic                  lamp_on,
    input  wire logic                  power_fail_seen,
    input  wire logic                  firmware_new,
    input  wire logic                  any_key,
    output alarm_pkg::leds_s           leds,
    output logic                       sounder,
    output logic [2:0]                 fault_latched
);

    // ------------------------------------------------------------
    // one-second tick
    // ------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic        tick;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_CYCLES_P - 1) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
            tick     <= 1'b0;
        end
    end

    logic blink;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            blink <= 1'b0;
        end else if (tick) begin
            blink <= ~blink;
        end
    end

    // ------------------------------------------------------------
    // calibration and limits
    // ------------------------------------------------------------
    logic [11:0] nominal;
    logic [11:0] low_ofs;
    logic [11:0] high_ofs;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            nominal  <= alarm_pkg::NOMINAL_RST;
            low_ofs  <= alarm_pkg::LOW_OFS_RST;
            high_ofs <= alarm_pkg::HIGH_OFS_RST;
        end else begin
            if (cal_capture) begin
                nominal <= pressure;
            end
            if (offset_load) begin
                low_ofs  <= low_offset;
                high_ofs <= high_offset;
            end
        end
    end

    // low limit saturates at zero; high limit is a 13-bit sum and never wraps
    logic [12:0] low_lim;
    logic [12:0] high_lim;
    logic [2:0]  cond;

    always_comb begin
        low_lim  = (nominal > low_ofs) ? {1'b0, nominal - low_ofs} : 13'h0;
        high_lim = {1'b0, nominal} + {1'b0, high_ofs};
        cond[alarm_pkg::F_LOW]   = {1'b0, pressure} < low_lim;
        cond[alarm_pkg::F_HIGH]  = {1'b0, pressure} > high_lim;
        cond[alarm_pkg::F_SPEED] = speed_lost;
    end

    // ------------------------------------------------------------
    // persistence qualify and latch
    // ------------------------------------------------------------
    logic blower_q;
    logic clear_faults;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            blower_q <= 1'b0;
        end else begin
            blower_q <= blower_on;
        end
    end

    // off-to-on edge clears; power cycle is rst_n
    assign clear_faults = blower_on & ~blower_q;

    logic [3:0] persist [alarm_pkg::FAULT_N];
    logic [2:0] new_fault;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_latched <= 3'h0;
            new_fault     <= 3'h0;
            for (int i = 0; i < alarm_pkg::FAULT_N; i++) begin
                persist[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < alarm_pkg::FAULT_N; i++) begin
                new_fault[i] <= 1'b0;
                if (!cond[i]) begin
                    persist[i] <= 4'h0;
                end else if (tick && persist[i] != 4'(alarm_pkg::QUALIFY_SEC + 1)) begin
                    persist[i] <= persist[i] + 4'h1;
                end
                // eleventh tick: a partial first second never shortens the wait
                // set wins over clear
                if (cond[i] && persist[i] == 4'(alarm_pkg::QUALIFY_SEC + 1)) begin
                    fault_latched[i] <= 1'b1;
                    new_fault[i]     <= ~fault_latched[i];
                end else if (clear_faults) begin
                    fault_latched[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // sounder
    // ------------------------------------------------------------
    alarm_pkg::sounder_e snd_state;
    logic [4:0]          snd_sec;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            snd_state <= alarm_pkg::SND_IDLE;
            snd_sec   <= 5'h0;
            sounder   <= 1'b0;
        end else begin
            sounder <= 1'b0;
            case (snd_state)
                alarm_pkg::SND_IDLE: begin
                    if (|new_fault) begin
                        snd_state <= alarm_pkg::SND_SIREN;
                        snd_sec   <= 5'h0;
                    end
                end
                alarm_pkg::SND_SIREN: begin
                    sounder <= 1'b1;
                    if (|new_fault) begin
                        snd_sec <= 5'h0;
                    end else if (~|fault_latched) begin
                        // cleared mid-siren: fall silent at once
                        snd_state <= alarm_pkg::SND_IDLE;
                        sounder   <= 1'b0;
                    end else if (tick) begin
                        if (snd_sec == 5'(alarm_pkg::SIREN_SEC - 1)) begin
                            snd_state <= alarm_pkg::SND_CHIRP;
                            snd_sec   <= 5'h0;
                            sounder   <= 1'b0;
                        end else begin
                            snd_sec <= snd_sec + 5'h1;
                        end
                    end
                end
                alarm_pkg::SND_CHIRP: begin
                    if (|new_fault) begin
                        snd_state <= alarm_pkg::SND_SIREN;
                        snd_sec   <= 5'h0;
                    end else if (~|fault_latched) begin
                        snd_state <= alarm_pkg::SND_IDLE;
                    end else if (tick) begin
                        // one-second chirp at the start of each period
                        if (snd_sec == 5'(alarm_pkg::CHIRP_PERIOD_SEC - 1)) begin
                            snd_sec <= 5'h0;
                        end else begin
                            snd_sec <= snd_sec + 5'h1;
                        end
                    end
                    if (snd_sec == 5'h0 && |fault_latched) begin
                        sounder <= 1'b1;
                    end
                end
                default: begin
                    snd_state <= alarm_pkg::SND_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // power interruption and firmware flags
    // ------------------------------------------------------------
    logic pwr_flag;
    logic fw_flag;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pwr_flag <= 1'b0;
            fw_flag  <= 1'b0;
        end else begin
            if (power_fail_seen) begin
                pwr_flag <= 1'b1;
            end else if (any_key) begin
                pwr_flag <= 1'b0;
            end
            if (firmware_new) begin
                fw_flag <= 1'b1;
            end else if (any_key) begin
                fw_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // indicators
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            leds <= '0;
        end else begin
            leds.flow_left_red  <= fault_latched[alarm_pkg::F_LOW];
            leds.flow_right_red <= fault_latched[alarm_pkg::F_HIGH];
            leds.blower_red     <= fault_latched[alarm_pkg::F_SPEED] & blink;
            leds.alarm_red      <= (|fault_latched) | (pwr_flag & blink);
            leds.bar_blink      <= fw_flag & blink;
            leds.blower_green   <= blower_on;
            leds.light_blue     <= lamp_on;
        end
    end

endmodule

`default_nettype wire

// >>> tb/panel_model.sv
// front panel key model: one key stroke gives a one-cycle press pulse
`timescale 1ns/1ps
`default_nettype none
module panel_model (
    input  wire logic mclk,
    input  wire logic press,
    output logic      any_key
);
    logic held = 1'b0;
    initial any_key = 1'b0;
    always @(posedge mclk) begin
        held <= press;
        any_key <= press && !held;
    end
endmodule
`default_nettype wire

// >>> tb/airflow_alarm_annunciator_asserts.sv
// port assertions for the alarm annunciator
`timescale 1ns/1ps
`default_nettype none
module airflow_alarm_asserts #(
    parameter int unsigned TICK_CYCLES_P = 20
) (
    input wire logic             mclk,
    input wire logic             rst_n,
    input wire logic             speed_lost,
    input wire logic             blower_on,
    input wire logic             lamp_on,
    input wire alarm_pkg::leds_s leds,
    input wire logic             sounder,
    input wire logic [2:0]       fault_latched
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [15:0] run_len;
    always_ff @(posedge mclk) begin
        if (!rst_n || !speed_lost) run_len <= 16'h0000;
        else if (run_len != 16'hffff) run_len <= run_len + 16'h0001;
    end
    sequence siren_on;
        sounder [*8];
    endsequence
    green_follow_a: assert property (blower_on |=> leds.blower_green) else $error("green");
    blue_follow_a: assert property (lamp_on |=> leds.light_blue) else $error("blue");
    latch_hold_a: assert property (fault_latched[2] && !$rose(blower_on) |=> fault_latched[2])
        else $error("latch lost");
    alarm_steady_a: assert property (|fault_latched |=> leds.alarm_red) else $error("alarm");
    left_red_a: assert property (fault_latched[0] |=> leds.flow_left_red) else $error("left");
    right_red_a: assert property (fault_latched[1] |=> leds.flow_right_red) else $error("right");
    siren_start_a: assert property ($rose(fault_latched[2]) |-> ##2 siren_on)
        else $error("siren");
    quiet_clear_a: assert property ((fault_latched == 3'h0) [*3] |-> !sounder)
        else $error("sounder on");
    qualify_time_a: assert property ($rose(fault_latched[2]) |-> run_len >= 10 * TICK_CYCLES_P)
        else $error("early latch");
endmodule
bind airflow_alarm_annunciator airflow_alarm_asserts #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk (
    .mclk(mclk), .rst_n(rst_n), .speed_lost(speed_lost), .blower_on(blower_on),
    .lamp_on(lamp_on), .leds(leds), .sounder(sounder), .fault_latched(fault_latched));
`default_nettype wire

// >>> tb/airflow_alarm_annunciator_test.sv
// self-checking bench for the alarm annunciator
`timescale 1ns/1ps
`default_nettype none
module airflow_alarm_annunciator_test;
    localparam int unsigned T = 20;
    logic mclk = 1'b0, rst_n = 1'b0, cal_capture = 1'b0, offset_load = 1'b0, speed_lost = 1'b0;
    logic blower_on = 1'b0, lamp_on = 1'b0, power_fail_seen = 1'b0, firmware_new = 1'b0;
    logic press = 1'b0;
    logic [11:0] pressure = 12'h800, high_offset = 12'h100, low_offset = 12'h100;
    logic any_key, sounder;
    logic [2:0] fault_latched;
    alarm_pkg::leds_s leds;
    logic [15:0] c;
    int miscompares = 0, checks_done = 0, w;
    initial forever #2.5 mclk = ~mclk;
    panel_model panel (.mclk(mclk), .press(press), .any_key(any_key));
    airflow_alarm_annunciator #(.TICK_CYCLES_P(T)) dut (
        .mclk(mclk), .rst_n(rst_n), .pressure(pressure), .cal_capture(cal_capture),
        .low_offset(low_offset), .high_offset(high_offset), .offset_load(offset_load),
        .speed_lost(speed_lost), .blower_on(blower_on), .lamp_on(lamp_on),
        .power_fail_seen(power_fail_seen), .firmware_new(firmware_new), .any_key(any_key),
        .leds(leds), .sounder(sounder), .fault_latched(fault_latched));
    task automatic end_of_test();
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic edge_n(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // cycles in a window where any masked output is high
    task automatic cnt(input logic [7:0] m, input int n);
        c = 16'h0000;
        repeat (n) begin
            @(negedge mclk);
            if (({sounder, leds} & m) != 8'h00) c = c + 16'h0001;
        end
    endtask
    task automatic wlatch(input int b);
        w = 0;
        while (fault_latched[b] !== 1'b1) begin
            @(negedge mclk);
            w++;
            if (w > 12 * T) begin
                miscompares++;
                end_of_test();
            end
        end
    endtask
    task automatic do_reset();
        edge_n(1);
        rst_n <= 1'b0;
        edge_n(6);
        rst_n <= 1'b1;
    endtask
    task automatic s_speed();
        edge_n(1);
        speed_lost <= 1'b1;
        edge_n(10 * T - 2);
        speed_lost <= 1'b0;
        cyc(12 * T);
        chk(fault_latched, 16'h0);
        edge_n(1);
        speed_lost <= 1'b1;
        wlatch(2);
        chk(16'(w >= 10 * T), 16'h1);
        edge_n(1);
        speed_lost <= 1'b0;
        cnt(8'h08, 2 * T);
        chk(c, T);
        chk(leds.alarm_red, 16'h1);
        cnt(8'h80, 25 * T);
        chk(c, 25 * T);
        chk(fault_latched, 16'h4);
        cyc(6 * T);
        cnt(8'h80, 10 * T);
        chk(c, T);
        edge_n(1);
        blower_on <= 1'b1;
        cyc(3);
        chk(fault_latched, 16'h0);
        chk(leds.blower_green, 16'h1);
        cyc(3);
        chk(sounder, 16'h0);
        edge_n(1);
        blower_on <= 1'b0;
    endtask
    task automatic s_press();
        edge_n(1);
        pressure <= 12'h6ff;
        wlatch(0);
        cyc(2);
        chk({leds.flow_left_red, leds.alarm_red}, 16'h3);
        do_reset();
        cyc(1);
        chk(fault_latched, 16'h0);
        edge_n(1);
        pressure <= 12'h400;
        cal_capture <= 1'b1;
        low_offset <= 12'h080;
        high_offset <= 12'h080;
        offset_load <= 1'b1;
        edge_n(1);
        cal_capture <= 1'b0;
        offset_load <= 1'b0;
        pressure <= 12'h480;
        cyc(12 * T);
        chk(fault_latched, 16'h0);
        edge_n(1);
        pressure <= 12'h380;
        cyc(12 * T);
        chk(fault_latched, 16'h0);
        edge_n(1);
        pressure <= 12'h37f;
        wlatch(0);
        chk(fault_latched, 16'h1);
        edge_n(1);
        pressure <= 12'h481;
        blower_on <= 1'b1;
        edge_n(1);
        blower_on <= 1'b0;
        wlatch(1);
        cyc(2);
        chk({leds.flow_right_red, leds.flow_left_red}, 16'h2);
        do_reset();
        wlatch(0);
        chk(fault_latched, 16'h1);
        edge_n(1);
        pressure <= 12'h800;
        do_reset();
    endtask
    task automatic s_flag(input logic [7:0] m, input logic fw);
        edge_n(1);
        power_fail_seen <= !fw;
        firmware_new <= fw;
        edge_n(1);
        power_fail_seen <= 1'b0;
        firmware_new <= 1'b0;
        cyc(2);
        cnt(m, 2 * T);
        chk(c, T);
        edge_n(1);
        press <= 1'b1;
        edge_n(1);
        press <= 1'b0;
        cyc(3);
        cnt(m, 2 * T);
        chk(c, 16'h0);
    endtask
    initial begin
        do_reset();
        s_speed();
        s_press();
        s_flag(8'h40, 1'b0);
        s_flag(8'h01, 1'b1);
        edge_n(1);
        lamp_on <= 1'b1;
        cyc(2);
        chk(leds.light_blue, 16'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
